/* verilog/pmux_top.sv */
// Purpose: port direction, pull-up and alternate-function pin sharing
// Assumes: peripherals on pclk; pins synchronised before use
// Notes: pin outputs lag register and peripheral changes by one cycle
`timescale 1ns/100ps
module pmux_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmux_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pmux_pkg::NPORT-1:0][7:0] pin_i,
    output logic [pmux_pkg::NPORT-1:0][7:0] pin_o,
    output logic [pmux_pkg::NPORT-1:0][7:0] pin_oe,
    output logic [pmux_pkg::NPORT-1:0][7:0] pin_pu,
    input wire logic timer_out_i,
    input wire logic pwm_out_i,
    input wire logic auto_xfer_strobe_i,
    input wire logic rt_trigger_i,
    output logic wide_timer_clk_in,
    output logic wide_timer_capture_in,
    output logic auto_xfer_busy,
    output logic [pmux_pkg::NIRQ-1:0] ext_irq,
    output logic irq
);
    import pmux_pkg::*;

    logic [NPORT-1:0][7:0] sync1_q, sync2_q;
    logic [NPORT-1:0][7:0] latch_q, latch_d, dir_q, dir_d;
    logic [NPORT-1:0][7:0] pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
    logic [NPORT-1:0][7:0] pin_pu_q, pin_pu_d, rd_val;
    logic [NPORT-1:0] pull_q, pull_d;
    logic [7:0] analog_q, analog_d, clkctrl_q, clkctrl_d;
    logic [4:0] alt_q, alt_d;
    logic [NIRQ-1:0] rise_q, rise_d, fall_q, fall_d, irq_ev;
    logic [7:0] rt_buf_q, rt_buf_d, rt_latch_q, rt_latch_d;
    logic [1:0] rt_trig_q, rt_trig_d;
    logic [15:0] ext_addr_q, ext_addr_d;
    logic [7:0] ext_wdata_q, ext_wdata_d, ext_rdata_q, ext_rdata_d;
    logic ext_wr_q, ext_wr_d;
    pmux_ext_e ext_st_q, ext_st_d;
    logic [1:0] ext_cnt_q, ext_cnt_d;
    logic [7:0] sts_q, sts_d, mask_q, mask_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
    logic clk_in_q, busy_q;
    logic setup, wr_acc, rd_sts, is_port, start, ev_done, rt_fire;
    logic [3:0] idx;
    logic [7:0] oe_v;

    pmux_edge #(.N(NIRQ)) u_edge (
        .clk(pclk),
        .rst_n(presetn),
        .lvl(sync2_q[P0][NIRQ-1:0]),
        .rise_en(rise_q),
        .fall_en(fall_q),
        .ev(irq_ev)
    );

    // bus decode, register writes, external bus engine, status
    always_comb begin
        latch_d = latch_q;
        dir_d = dir_q;
        pull_d = pull_q;
        analog_d = analog_q;
        clkctrl_d = clkctrl_q;
        alt_d = alt_q;
        rise_d = rise_q;
        fall_d = fall_q;
        rt_buf_d = rt_buf_q;
        rt_trig_d = rt_trig_q;
        ext_addr_d = ext_addr_q;
        ext_wdata_d = ext_wdata_q;
        ext_rdata_d = ext_rdata_q;
        ext_wr_d = ext_wr_q;
        ext_st_d = ext_st_q;
        ext_cnt_d = ext_cnt_q;
        mask_d = mask_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        ev_done = 1'b0;
        setup = psel & ~penable;
        wr_acc = psel & penable & pready_q & pwrite;
        rd_sts = psel & penable & pready_q & ~pwrite & (paddr == STS_OFF);
        idx = paddr[5:2];
        is_port = idx < 4'(NPORT);
        pready_d = setup;
        start = 1'b0;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            if (paddr[11:6] == DATA_PAGE && is_port)
                prdata_d[7:0] = rd_val[idx];
            else if (paddr[11:6] == DIR_PAGE && is_port)
                prdata_d[7:0] = dir_q[idx];
            else begin
                unique case (paddr)
                    PULL_OFF: prdata_d[NPORT-1:0] = pull_q;
                    ANALOG_OFF: prdata_d[7:0] = analog_q;
                    CLKCTRL_OFF: prdata_d[7:0] = clkctrl_q;
                    ALTSEL_OFF: prdata_d[4:0] = alt_q;
                    RISE_OFF: prdata_d[NIRQ-1:0] = rise_q;
                    FALL_OFF: prdata_d[NIRQ-1:0] = fall_q;
                    RTBUF_OFF: prdata_d[7:0] = rt_buf_q;
                    RTTRIG_OFF: prdata_d[1:0] = rt_trig_q;
                    EXTADDR_OFF: prdata_d[15:0] = ext_addr_q;
                    EXTWDATA_OFF: prdata_d[7:0] = ext_wdata_q;
                    EXTCMD_OFF: prdata_d[15:0] = {ext_rdata_q, 6'h00,
                        ext_wr_q, ext_st_q != EXT_IDLE};
                    STS_OFF: prdata_d[7:0] = sts_q;
                    MASK_OFF: prdata_d[7:0] = mask_q;
                    default: pslverr_d = 1'b1;
                endcase
            end
        end
        if (wr_acc) begin
            if (paddr[11:6] == DATA_PAGE && is_port)
                latch_d[idx] = pwdata[7:0];
            else if (paddr[11:6] == DIR_PAGE && is_port)
                dir_d[idx] = pwdata[7:0] & DIR_MASK[idx];
            else begin
                unique case (paddr)
                    PULL_OFF: pull_d = pwdata[NPORT-1:0];
                    ANALOG_OFF: analog_d = pwdata[7:0];
                    CLKCTRL_OFF: clkctrl_d = pwdata[7:0];
                    ALTSEL_OFF: alt_d = pwdata[4:0];
                    RISE_OFF: rise_d = pwdata[NIRQ-1:0];
                    FALL_OFF: fall_d = pwdata[NIRQ-1:0];
                    RTBUF_OFF: rt_buf_d = pwdata[7:0];
                    RTTRIG_OFF: rt_trig_d = pwdata[1:0];
                    EXTADDR_OFF: ext_addr_d = pwdata[15:0];
                    EXTWDATA_OFF: ext_wdata_d = pwdata[7:0];
                    EXTCMD_OFF: start = pwdata[CMD_START_BIT];
                    MASK_OFF: mask_d = pwdata[7:0];
                    default: ;
                endcase
            end
        end
        // write latch is moved out only on the chosen trigger
        rt_fire = (rt_trig_q[0] & rt_trigger_i) | (rt_trig_q[1] & irq_ev[0]);
        rt_latch_d = rt_fire ? rt_buf_q : rt_latch_q;
        unique case (ext_st_q)
            EXT_IDLE: begin
                if (start && alt_q[ALT_EXT]) begin
                    ext_st_d = EXT_ADDR;
                    ext_wr_d = pwdata[CMD_WRITE_BIT];
                end
            end
            EXT_ADDR: ext_st_d = EXT_HOLD;
            EXT_HOLD: begin
                ext_st_d = EXT_STRB;
                ext_cnt_d = EXT_STRB_LAST;
            end
            EXT_STRB: begin
                if (ext_cnt_q != 2'h0)
                    ext_cnt_d = ext_cnt_q - 2'h1;
                else if (sync2_q[P6][6]) begin
                    ext_st_d = EXT_DONE;
                    if (!ext_wr_q)
                        ext_rdata_d = sync2_q[P4];
                end
            end
            EXT_DONE: begin
                ext_st_d = EXT_IDLE;
                ev_done = 1'b1;
            end
            default: ext_st_d = EXT_IDLE;
        endcase
        // only bits already shown to the reader are cleared; set wins
        sts_d = (sts_q & ~(rd_sts ? prdata_q[7:0] : 8'h00))
            | {ev_done, irq_ev};
        irq_d = |(sts_q & mask_q);
    end

    // pin drive, pull-up and read-back, with alternate functions on top
    always_comb begin
        oe_v = 8'h00;
        for (int i = 0; i < NPORT; i++) begin
            oe_v = dir_q[i] & DIR_MASK[i];
            if (i == P4)
                oe_v = {8{dir_q[P4][0]}};
            pin_o_d[i] = latch_q[i];
            pin_oe_d[i] = oe_v;
            pin_pu_d[i] = {8{pull_q[i]}} & ~oe_v & DIR_MASK[i];
            rd_val[i] = (oe_v & latch_q[i]) | (~oe_v & sync2_q[i]);
        end
        rd_val[P0][7] = sync2_q[P0][7] & clkctrl_q[CLK_SUBIN_BIT];
        pin_pu_d[P1] = pin_pu_d[P1] & ~analog_q;
        // open drain: only ever pulls low, pull-up fixed by mask option
        pin_o_d[P6][3:0] = 4'h0;
        pin_oe_d[P6][3:0] = dir_q[P6][3:0] & ~latch_q[P6][3:0];
        pin_pu_d[P6][3:0] = MASK_PU_P6;
        rd_val[P6][3:0] = sync2_q[P6][3:0];
        if (alt_q[ALT_TO]) begin
            pin_o_d[P3][0] = alt_q[ALT_PWM] ? pwm_out_i : timer_out_i;
            pin_oe_d[P3][0] = 1'b1;
            pin_pu_d[P3][0] = 1'b0;
        end
        if (alt_q[ALT_STB]) begin
            pin_o_d[P2][3] = auto_xfer_strobe_i;
            pin_oe_d[P2][4:3] = 2'b01;
            pin_pu_d[P2][3] = 1'b0;
        end
        if (alt_q[ALT_RT]) begin
            pin_o_d[P12] = rt_latch_q;
            pin_oe_d[P12] = 8'hFF;
            pin_pu_d[P12] = 8'h00;
        end
        if (alt_q[ALT_EXT]) begin
            pin_o_d[P5] = ext_addr_q[15:8];
            pin_oe_d[P5] = 8'hFF;
            pin_pu_d[P5] = 8'h00;
            pin_o_d[P4] = (ext_st_q == EXT_STRB) ? ext_wdata_q
                : ext_addr_q[7:0];
            pin_oe_d[P4] = {8{(ext_st_q == EXT_ADDR)
                || (ext_st_q == EXT_HOLD)
                || (ext_st_q == EXT_STRB && ext_wr_q)}};
            pin_pu_d[P4] = {8{pull_q[P4]}} & ~pin_oe_d[P4];
            pin_o_d[P6][7:4] = {ext_st_q == EXT_ADDR, 1'b1,
                !(ext_st_q == EXT_STRB && ext_wr_q),
                !(ext_st_q == EXT_STRB && !ext_wr_q)};
            pin_oe_d[P6][7:4] = 4'b1011;
            pin_pu_d[P6][7] = 1'b0;
            pin_pu_d[P6][5:4] = 2'b00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            latch_q <= '0;
            dir_q <= '0;
            pin_o_q <= '0;
            pin_oe_q <= '0;
            pin_pu_q <= '0;
            pull_q <= '0;
            analog_q <= BYTE_RST;
            clkctrl_q <= BYTE_RST;
            alt_q <= '0;
            rise_q <= '0;
            fall_q <= '0;
            rt_buf_q <= BYTE_RST;
            rt_latch_q <= BYTE_RST;
            rt_trig_q <= '0;
            ext_addr_q <= '0;
            ext_wdata_q <= BYTE_RST;
            ext_rdata_q <= BYTE_RST;
            ext_wr_q <= 1'b0;
            ext_st_q <= EXT_IDLE;
            ext_cnt_q <= '0;
            sts_q <= BYTE_RST;
            mask_q <= BYTE_RST;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            clk_in_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            latch_q <= latch_d;
            dir_q <= dir_d;
            pin_o_q <= pin_o_d;
            pin_oe_q <= pin_oe_d;
            pin_pu_q <= pin_pu_d;
            pull_q <= pull_d;
            analog_q <= analog_d;
            clkctrl_q <= clkctrl_d;
            alt_q <= alt_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            rt_buf_q <= rt_buf_d;
            rt_latch_q <= rt_latch_d;
            rt_trig_q <= rt_trig_d;
            ext_addr_q <= ext_addr_d;
            ext_wdata_q <= ext_wdata_d;
            ext_rdata_q <= ext_rdata_d;
            ext_wr_q <= ext_wr_d;
            ext_st_q <= ext_st_d;
            ext_cnt_q <= ext_cnt_d;
            sts_q <= sts_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            clk_in_q <= sync2_q[P0][0];
            busy_q <= sync2_q[P2][4];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_o = pin_o_q;
    assign pin_oe = pin_oe_q;
    assign pin_pu = pin_pu_q;
    assign irq = irq_q;
    assign ext_irq = irq_ev;
    assign wide_timer_clk_in = clk_in_q;
    assign wide_timer_capture_in = irq_ev[1];
    assign auto_xfer_busy = busy_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_addr_phase;
        ext_st_q == EXT_ADDR ##1 ext_st_q == EXT_HOLD ##1 ext_st_q == EXT_STRB;
    endsequence

    chk_reset_inputs: assert property ($rose(presetn) |-> pin_oe_q == '0)
        else $error("pin driven right after reset");
    chk_p4_common_dir: assert property (
        !alt_q[ALT_EXT] |=> pin_oe_q[P4] == 8'h00 || pin_oe_q[P4] == 8'hFF)
        else $error("port 4 bits differ in direction");
    chk_analog_no_pu: assert property (
        1'b1 |=> (pin_pu_q[P1] & $past(analog_q)) == 8'h00)
        else $error("pull-up on analog input");
    chk_od_fixed: assert property (
        1'b1 |=> pin_pu_q[P6][3:0] == MASK_PU_P6 && pin_o_q[P6][3:0] == 4'h0)
        else $error("open drain bits not fixed");
    chk_rt_hold: assert property (
        !rt_fire |=> $stable(rt_latch_q))
        else $error("real-time data moved without trigger");
    chk_rt_load: assert property (
        rt_fire |=> rt_latch_q == $past(rt_buf_q))
        else $error("real-time data not loaded on trigger");
    chk_addr_latch_strobe_phase: assert property (
        ext_st_q == EXT_ADDR |-> seq_addr_phase)
        else $error("address phase out of order");
    chk_addr_latch_strobe_pin: assert property (
        alt_q[ALT_EXT] && ext_st_q == EXT_ADDR |=> pin_o_q[P6][7]
            ##1 !pin_o_q[P6][7])
        else $error("address strobe not a single pulse");
    chk_wait_stall: assert property (
        ext_st_q == EXT_STRB && ext_cnt_q == 2'h0 && !sync2_q[P6][6]
            |=> ext_st_q == EXT_STRB)
        else $error("strobe ended during wait");
    chk_stb_busy_dir: assert property (
        alt_q[ALT_STB] |=> pin_oe_q[P2][3] && !pin_oe_q[P2][4])
        else $error("strobe/busy pin directions wrong");
    chk_done_sets: assert property (
        ext_st_q == EXT_DONE |=> sts_q[STS_DONE_BIT])
        else $error("done event lost");
endmodule

/* inc/pmux_pkg.sv */
// Purpose: shared constants, register map and types of the port mux block
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes: port slot order is P0..P7, then P12, P13
package pmux_pkg;
    localparam int NPORT = 10;
    localparam int NIRQ = 7;
    localparam int P0 = 0;
    localparam int P1 = 1;
    localparam int P2 = 2;
    localparam int P3 = 3;
    localparam int P4 = 4;
    localparam int P5 = 5;
    localparam int P6 = 6;
    localparam int P12 = 8;
    localparam int ADDR_W = 12;
    // bits that own a direction control; input-only and absent bits are 0
    localparam logic [NPORT-1:0][7:0] DIR_MASK = {8'h03, 8'hFF, 8'h07,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7E};
    localparam logic [5:0] DATA_PAGE = 6'h00;
    localparam logic [5:0] DIR_PAGE = 6'h01;
    localparam logic [ADDR_W-1:0] PULL_OFF = 12'h080;
    localparam logic [ADDR_W-1:0] ANALOG_OFF = 12'h084;
    localparam logic [ADDR_W-1:0] CLKCTRL_OFF = 12'h088;
    localparam logic [ADDR_W-1:0] ALTSEL_OFF = 12'h08C;
    localparam logic [ADDR_W-1:0] RISE_OFF = 12'h090;
    localparam logic [ADDR_W-1:0] FALL_OFF = 12'h094;
    localparam logic [ADDR_W-1:0] RTBUF_OFF = 12'h098;
    localparam logic [ADDR_W-1:0] RTTRIG_OFF = 12'h09C;
    localparam logic [ADDR_W-1:0] EXTADDR_OFF = 12'h0A0;
    localparam logic [ADDR_W-1:0] EXTWDATA_OFF = 12'h0A4;
    localparam logic [ADDR_W-1:0] EXTCMD_OFF = 12'h0A8;
    localparam logic [ADDR_W-1:0] STS_OFF = 12'h0AC;
    localparam logic [ADDR_W-1:0] MASK_OFF = 12'h0B0;
    localparam int ALT_EXT = 0;
    localparam int ALT_TO = 1;
    localparam int ALT_PWM = 2;
    localparam int ALT_STB = 3;
    localparam int ALT_RT = 4;
    localparam int CLK_SUBIN_BIT = 6;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int STS_DONE_BIT = 7;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] MASK_PU_P6 = 4'h0;
    localparam int PCLK_NS = 40;
    localparam int EXT_STRB_NS = 80;
    localparam int EXT_STRB_CYC = (EXT_STRB_NS + PCLK_NS - 1) / PCLK_NS;
    localparam logic [1:0] EXT_STRB_LAST = 2'(EXT_STRB_CYC - 1);
    typedef enum logic [2:0] {
        EXT_IDLE = 3'b000,
        EXT_ADDR = 3'b001,
        EXT_HOLD = 3'b011,
        EXT_STRB = 3'b010,
        EXT_DONE = 3'b110
    } pmux_ext_e;
endpackage

/* verilog/pmux_edge.sv */
// Purpose: edge detector for the external interrupt pins
// Assumes: inputs already synchronised to clk
// Notes: events are held off until the synchroniser shows real pin levels
`timescale 1ns/100ps
module pmux_edge #(
    parameter int N = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] lvl,
    input wire logic [N-1:0] rise_en,
    input wire logic [N-1:0] fall_en,
    output logic [N-1:0] ev
);
    logic [N-1:0] prev_q, prev_d, ev_q, ev_d;
    logic [1:0] arm_q, arm_d;

    always_comb begin
        prev_d = lvl;
        // a pin idling high would look like a rising edge until the
        // reset zeros have left both synchroniser stages and prev_q
        arm_d = (arm_q == 2'h3) ? arm_q : arm_q + 2'h1;
        ev_d = {N{arm_q == 2'h3}} & ((rise_en & lvl & ~prev_q)
                | (fall_en & ~lvl & prev_q));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= '0;
            ev_q <= '0;
            arm_q <= 2'h0;
        end else begin
            prev_q <= prev_d;
            ev_q <= ev_d;
            arm_q <= arm_d;
        end
    end

    assign ev = ev_q;

    chk_edge_cause: assert property (
        @(posedge clk) disable iff (!rst_n)
        ev != '0 |-> (ev & ~(($past(rise_en) & $past(lvl) & ~$past(lvl, 2))
            | ($past(fall_en) & ~$past(lvl) & $past(lvl, 2)))) == '0)
        else $error("edge event without selected edge");
endmodule

/* testbench/pmux_board.sv */
// Purpose: board and external memory model at the port pins
// Assumes: pin outputs are registered on clk
// Notes: memory returns address low xor address high on a read
`timescale 1ns/100ps
module pmux_board
    import pmux_pkg::*;
(
    input wire logic clk,
    input wire logic [NPORT-1:0][7:0] pin_o,
    input wire logic [NPORT-1:0][7:0] pin_oe,
    input wire logic [NPORT-1:0][7:0] pin_pu,
    input wire logic [NPORT-1:0][7:0] drv,
    output logic [NPORT-1:0][7:0] pin_i,
    output logic [15:0] lat_addr,
    output logic [7:0] wr_byte,
    output logic [7:0] rd_len
);
    logic rd_act, wr_act, addr_latch_strobe;
    logic rd_prev = 1'b0;
    logic [2:0] wcnt = 3'h0;
    logic [7:0] rd_cnt = 8'h00;
    initial lat_addr = 16'h0000;
    initial wr_byte = 8'h00;
    initial rd_len = 8'h00;
    assign rd_act = pin_oe[P6][4] && !pin_o[P6][4];
    assign wr_act = pin_oe[P6][5] && !pin_o[P6][5];
    assign addr_latch_strobe = pin_oe[P6][7] && pin_o[P6][7];
    always_comb begin
        for (int s = 0; s < NPORT; s++) begin
            for (int b = 0; b < 8; b++) begin
                pin_i[s][b] = pin_oe[s][b] ? pin_o[s][b]
                    : (pin_pu[s][b] | drv[s][b]);
            end
        end
        // memory drives the low bus only while the read strobe is low
        if (rd_act && !pin_oe[P4][0]) begin
            pin_i[P4] = lat_addr[7:0] ^ lat_addr[15:8];
        end
        // wait goes low with the address strobe, so the synchronised
        // level already holds the second strobe cycle, the first one that samples it
        if (!pin_oe[P6][6]) begin
            pin_i[P6][6] = !addr_latch_strobe && (wcnt == 3'h0);
        end
    end
    always @(posedge clk) begin
        if (addr_latch_strobe) begin
            lat_addr <= {pin_o[P5], pin_o[P4]};
            wcnt <= 3'h4;
        end else if (wcnt != 3'h0) begin
            wcnt <= wcnt - 3'h1;
        end
        if (wr_act) begin
            wr_byte <= pin_o[P4];
        end
        rd_cnt <= rd_act ? rd_cnt + 8'h01 : 8'h00;
        if (rd_prev && !rd_act) begin
            rd_len <= rd_cnt;
        end
        rd_prev <= rd_act;
    end
endmodule

/* testbench/tb_top.sv */
// Purpose: self-checking bench of the port mux block
// Assumes: APB answers with one access cycle
// Notes: undriven pins take the bench drive value or their pull-up
`timescale 1ns/100ps
module tb_top;
    import pmux_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, wtc, wtcap, busy, irq;
    logic tmr = 1'b0, pwm = 1'b0, axs = 1'b0, rtt = 1'b0;
    logic [NIRQ-1:0] ext_irq;
    logic [NPORT-1:0][7:0] pin_i, pin_o, pin_oe, pin_pu, drv = '0;
    logic [15:0] lat_addr;
    logic [7:0] wr_byte, rd_len;
    int bad_count = 0, checks_done = 0, cyc = 0, caps = 0, rises = 0;
    pmux_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_pu(pin_pu), .timer_out_i(tmr),
        .pwm_out_i(pwm), .auto_xfer_strobe_i(axs), .rt_trigger_i(rtt),
        .wide_timer_clk_in(wtc), .wide_timer_capture_in(wtcap),
        .auto_xfer_busy(busy), .ext_irq(ext_irq), .irq(irq));
    pmux_board u_board (.clk(pclk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pu(pin_pu), .drv(drv), .pin_i(pin_i), .lat_addr(lat_addr),
        .wr_byte(wr_byte), .rd_len(rd_len));
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (wtcap === 1'b1) caps++;
        if (ext_irq[3] === 1'b1) rises++;
        if (cyc == 30000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input logic [79:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check(n, 1, "one access cycle");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_reset();
        check(pin_oe, '0, "oe after reset");
        check(pin_pu, '0, "pull after reset");
        apb(1'b0, 12'h0FC, 32'h0);
        check({err, rd}, {1'b1, 32'h0}, "unmapped read");
    endtask
    task automatic t_dir();
        for (int s = 0; s < NPORT; s++) begin
            apb(1'b1, 12'(64 + 4 * s), 32'hFF);
            idle(2);
            check(pin_oe[s], DIR_MASK[s], "dir per bit");
            if (s == 7) check(pin_oe[s], 8'h07, "port7 three");
            apb(1'b1, 12'(64 + 4 * s), 32'h0);
        end
        apb(1'b1, 12'h050, 32'h01);
        idle(2);
        check(pin_oe[P4], 8'hFF, "port4 whole");
        apb(1'b1, 12'h050, 32'hFE);
        idle(2);
        check(pin_oe[P4], 8'h00, "port4 bit0 only");
        apb(1'b1, 12'h044, 32'hFF);
        apb(1'b1, 12'h004, 32'hA5);
        idle(2);
        check(pin_o[P1], 8'hA5, "port1 data");
    endtask
    task automatic t_pull();
        int sl[6] = '{1, 2, 3, 4, 5, 8};
        apb(1'b1, 12'h044, 32'h0F);
        apb(1'b1, PULL_OFF, 32'h3FF);
        idle(2);
        check(pin_pu[P1], 8'hF0, "pull inputs only");
        apb(1'b1, 12'h044, 32'h0);
        idle(2);
        foreach (sl[i]) check(pin_pu[sl[i]], 8'hFF, "pull on");
        check(pin_pu[P6], 8'hF0, "open drain pull");
        apb(1'b1, ANALOG_OFF, 32'h0F);
        idle(2);
        check(pin_pu[P1], 8'hF0, "analog pull off");
        apb(1'b1, ANALOG_OFF, 32'h0);
        apb(1'b1, PULL_OFF, 32'h0);
    endtask
    task automatic t_subin();
        drv[P0][7] <= 1'b1;
        drv[P0][0] <= 1'b1;
        idle(4);
        check(wtc, 1'b1, "timer clock pin");
        apb(1'b0, 12'h000, 32'h0);
        check(rd[7], 1'b0, "p07 masked");
        apb(1'b1, CLKCTRL_OFF, 32'h40);
        apb(1'b0, 12'h000, 32'h0);
        check(rd[7], 1'b1, "p07 read");
    endtask
    task automatic t_edge();
        apb(1'b1, MASK_OFF, 32'h7F);
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, RISE_OFF, m[0] ? 32'h08 : 32'h0);
            apb(1'b1, FALL_OFF, m[1] ? 32'h08 : 32'h0);
            drv[P0][3] <= 1'b1;
            idle(6);
            check(irq, m[0], "irq rise");
            apb(1'b0, STS_OFF, 32'h0);
            check(rd[3], m[0], "status rise");
            drv[P0][3] <= 1'b0;
            idle(6);
            check(irq, m[1], "irq fall");
            apb(1'b0, STS_OFF, 32'h0);
            check(rd[3], m[1], "status fall");
            idle(2);
            check(irq, 1'b0, "irq cleared");
        end
        check(rises, 4, "edge pulses");
        apb(1'b1, MASK_OFF, 32'h0);
        apb(1'b1, RISE_OFF, 32'h02);
        drv[P0][1] <= 1'b1;
        idle(6);
        check(irq, 1'b0, "masked irq");
        check(32'(caps), 32'd1, "capture pulse");
        apb(1'b0, STS_OFF, 32'h0);
        check(rd[1], 1'b1, "masked status");
    endtask
    task automatic t_alt();
        apb(1'b1, 12'h04C, 32'h01);
        apb(1'b1, ALTSEL_OFF, 32'h02);
        tmr <= 1'b1;
        idle(3);
        check(pin_o[P3][0], 1'b1, "timer out");
        apb(1'b1, ALTSEL_OFF, 32'h06);
        idle(2);
        check(pin_o[P3][0], 1'b0, "pwm low");
        pwm <= 1'b1;
        idle(3);
        check(pin_o[P3][0], 1'b1, "pwm high");
        apb(1'b1, ALTSEL_OFF, 32'h08);
        apb(1'b1, 12'h048, 32'h08);
        axs <= 1'b1;
        drv[P2][4] <= 1'b1;
        idle(5);
        check(pin_o[P2][3], 1'b1, "xfer strobe");
        check(busy, 1'b1, "xfer busy");
        apb(1'b1, ALTSEL_OFF, 32'h10);
        apb(1'b1, 12'h060, 32'hFF);
        apb(1'b1, RTTRIG_OFF, 32'h01);
        apb(1'b1, RTBUF_OFF, 32'h3C);
        idle(3);
        check(pin_o[P12], 8'h00, "rt holds");
        rtt <= 1'b1;
        @(posedge pclk);
        rtt <= 1'b0;
        idle(3);
        check(pin_o[P12], 8'h3C, "rt loads");
    endtask
    task automatic ext_op(input logic [31:0] cmd);
        apb(1'b1, EXTCMD_OFF, cmd);
        while (irq !== 1'b1) begin
            @(posedge pclk);
        end
        check(irq, 1'b1, "bus done irq");
        apb(1'b0, STS_OFF, 32'h0);
        check(rd[7], 1'b1, "bus done status");
    endtask
    task automatic t_ext();
        apb(1'b1, ALTSEL_OFF, 32'h01);
        apb(1'b1, MASK_OFF, 32'h80);
        apb(1'b1, EXTADDR_OFF, 32'h12AB);
        ext_op(32'h1);
        check(lat_addr, 16'h12AB, "latched address");
        check(rd_len > 8'h04, 1'b1, "read held by wait");
        apb(1'b0, EXTCMD_OFF, 32'h0);
        check(rd[15:8], 8'hB9, "read data");
        apb(1'b1, EXTWDATA_OFF, 32'h5A);
        ext_op(32'h3);
        check(wr_byte, 8'h5A, "write data");
    endtask
    initial begin
        idle(2);
        presetn <= 1'b1;
        t_reset();
        t_dir();
        t_pull();
        t_subin();
        t_edge();
        t_alt();
        t_ext();
        stop_test();
    end
endmodule
